// ### design/sas_pkg.sv
// Shared constants of the converter sequencer: register map, fields, states and timing.
package sas_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] SAS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SAS_SEQ_OFS = 8'h04;
  localparam logic [7:0] SAS_TIMING_OFS = 8'h08;
  localparam logic [7:0] SAS_INSEL_OFS = 8'h0c;
  localparam logic [7:0] SAS_PINCFG_OFS = 8'h10;
  localparam logic [7:0] SAS_SCAN_OFS = 8'h14;
  localparam logic [7:0] SAS_STAT_OFS = 8'h18;
  localparam logic [7:0] SAS_MASK_OFS = 8'h1c;
  localparam logic [7:0] SAS_BUF_OFS = 8'h40;
  // Control register fields.
  localparam int SAS_ON_BIT = 0;
  localparam int SAS_SREQ_BIT = 1;
  localparam int SAS_DONE_BIT = 2;
  localparam int SAS_AUTO_SAMPLE_EN_BIT = 3;
  localparam int SAS_SIMULTANEOUS_SAMPLE_SEL_BIT = 4;
  localparam int SAS_TRIG_LSB = 5;
  localparam int SAS_FORM_LSB = 8;
  localparam int SAS_REF_BIT = 10;
  localparam logic [31:0] SAS_CTRL_WMASK = 32'h0000_07fb;
  // Sequence register fields.
  localparam int SAS_SMPI_LSB = 0;
  localparam int SAS_SPLIT_BIT = 4;
  localparam int SAS_ALTERNATE_INPUT_SEL_BIT = 5;
  localparam int SAS_CHPS_LSB = 6;
  localparam int SAS_HALF_BIT = 8;
  localparam logic [31:0] SAS_SEQ_WMASK = 32'h0000_00ff;
  // Timing register fields.
  localparam int SAS_DIV_LSB = 0;
  localparam int SAS_AUTO_SAMPLE_CLOCKS_LSB = 8;
  localparam logic [31:0] SAS_TIMING_WMASK = 32'h0000_1f3f;
  localparam logic [31:0] SAS_HALF_WMASK = 32'h0000_ffff;
  localparam logic [31:0] SAS_IRQ_WMASK = 32'h0000_0003;
  // Status bits: sample group stored, conversion aborted.
  localparam int SAS_ST_DONE = 0;
  localparam int SAS_ST_ABORT = 1;
  // Trigger source codes.
  localparam logic [2:0] SAS_TRIG_SW = 3'h0;
  localparam logic [2:0] SAS_TRIG_TIMER = 3'h1;
  localparam logic [2:0] SAS_TRIG_EXT = 3'h2;
  localparam logic [2:0] SAS_TRIG_AUTO = 3'h7;
  // Result width and conversion length in converter clock periods.
  localparam int SAS_RES_W = 10;
  localparam logic [3:0] SAS_CONV_TADS = 4'hc;
  localparam logic [3:0] SAS_LAST_STEP = 4'hb;
  localparam logic [9:0] SAS_SAR_MSB = 10'h200;
  // Sequencer states, Gray coded along idle, sample, convert.
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b11
  } sas_state_t;
endpackage

// ### design/sas_sequencer.sv
// Sequencer and register slave around a 10-bit successive-approximation converter.
`timescale 1ns/10ps
// What this block does
// - Each conversion yields a 10-bit unsigned code.
// - Sixteen inputs routed onto four sample-holds.
// - Sequencer keeps running during device sleep.
// - Software picks supply rails or reference pins.
// - Sixteen-entry result buffer, software read only.
// - Ten stored bits read as formatted word.
// - Software writes never change buffer entries.
// - Setting sample request starts acquisition.
// - Selected trigger ends acquisition, starts conversion.
// - Done and flag after programmed result count.
// - Registers for channels, pin mode, scan set.
// - Code 000 clear-start, 111 counted auto start.
// - Split mode alternates halves per interrupt.
// - Switching off aborts, wins over auto start.
// - Twelve converter clocks, period from divider.
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int BUF_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic timer_trig_in,
  input wire logic ext_trig_in,
  input wire logic comparator_in,
  output logic [9:0] dac_code_out,
  output logic [1:0] conv_chan_out,
  output logic [3:0] sh_track_out,
  output logic [15:0] input_sel_out,
  output logic ref_pins_sel_out,
  output logic [15:0] pin_analog_out,
  output logic irq_out
);

  // The address map holds exactly sixteen result slots.
  if (BUF_DEPTH != 16) begin : g_depth_check
    $error("BUF_DEPTH must be 16");
  end

  // Byte-lane merge of a Wishbone write into a register under a writable mask.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~(lanes & wmask)) | (wdat & lanes & wmask);
  endfunction

  // Formats a stored 10-bit result as integer, signed, fractional or signed fractional.
  function automatic logic [15:0] fmt(input logic [9:0] v, input logic [1:0] form);
    unique case (form)
      2'h0: return {6'h00, v};
      2'h1: return {{7{~v[9]}}, v[8:0]};
      2'h2: return {v, 6'h00};
      2'h3: return {~v[9], v[8:0], 6'h00};
    endcase
  endfunction

  sas_state_t state, next_state;
  logic [5:0] tad_cnt, next_tad_cnt;
  logic [4:0] acq_cnt, next_acq_cnt;
  logic [3:0] step, next_step;
  logic [1:0] chan, next_chan;
  logic [9:0] sar, next_sar;
  logic [3:0] sample_request_cnt, next_sample_request_cnt;
  logic [3:0] wr_ptr, next_wr_ptr;
  logic half, next_half;
  logic use_b, next_use_b;
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] seq, next_seq;
  logic [31:0] timing, next_timing;
  logic [31:0] insel, next_insel;
  logic [31:0] pincfg, next_pincfg;
  logic [31:0] scan, next_scan;
  logic [1:0] stat, next_stat;
  logic [1:0] mask, next_mask;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic irq, next_irq;
  logic [3:0] track, next_track;
  logic [15:0] chsel, next_chsel;
  logic buf_we;
  logic [9:0] rbuf [BUF_DEPTH];

  logic on, tad_tick, bus_req, bus_wr, bus_rd, is_buf, trig_hit, last_chan, group_done;
  logic [2:0] trig;
  logic [1:0] chps;
  logic [3:0] smpi;
  logic [4:0] auto_sample_clocks;

  // Field views of the control registers.
  assign on = ctrl[SAS_ON_BIT];
  assign trig = ctrl[SAS_TRIG_LSB +: 3];
  assign chps = seq[SAS_CHPS_LSB +: 2];
  assign smpi = seq[SAS_SMPI_LSB +: 4];
  assign auto_sample_clocks = timing[SAS_AUTO_SAMPLE_CLOCKS_LSB +: 5];
  // The converter clock period is (divider + 1) system clocks, the instruction cycle
  // being two system clocks, so all 64 divider values are usable.
  assign tad_tick = (tad_cnt == timing[SAS_DIV_LSB +: 6]);
  assign bus_req = wb_cyc_in & wb_stb_in & ~ack;
  assign bus_wr = bus_req & wb_we_in;
  assign bus_rd = bus_req & ~wb_we_in;
  assign is_buf = (wb_adr_in[7:6] == SAS_BUF_OFS[7:6]);
  assign last_chan = (chps == 2'h0) || (chps == 2'h1 && chan == 2'h1) || (chan == 2'h3);
  assign group_done = (sample_request_cnt == smpi);

  // Trigger decode: software clear, timer, external event or counted acquisition.
  always_comb begin
    unique case (trig)
      SAS_TRIG_SW: trig_hit = ~ctrl[SAS_SREQ_BIT];
      SAS_TRIG_TIMER: trig_hit = timer_trig_in;
      SAS_TRIG_EXT: trig_hit = ext_trig_in;
      // A zero count acts as one tick, so acquisition never lasts less than one period.
      SAS_TRIG_AUTO: trig_hit = tad_tick &&
                                ({1'b0, acq_cnt} + 6'h01 >= {1'b0, auto_sample_clocks});
      default: trig_hit = 1'b0;
    endcase
  end

  // Next values of the bus slave, registers and sequencer. No sleep input exists: the
  // sequencer runs on the converter's own clock path whatever the device does.
  always_comb begin
    next_state = state;
    next_tad_cnt = (tad_tick || state == SAS_IDLE) ? 6'h00 : tad_cnt + 6'h01;
    next_acq_cnt = acq_cnt;
    next_step = step;
    next_chan = chan;
    next_sar = sar;
    next_sample_request_cnt = sample_request_cnt;
    next_wr_ptr = wr_ptr;
    next_half = half;
    next_use_b = use_b;
    next_ctrl = ctrl;
    next_seq = seq;
    next_timing = timing;
    next_insel = insel;
    next_pincfg = pincfg;
    next_scan = scan;
    next_stat = stat;
    next_mask = mask;
    next_ack = bus_req;
    next_rdat = 32'h0000_0000;
    buf_we = 1'b0;
    // Register writes; buffer slots and unmapped offsets take none.
    if (bus_wr && !is_buf) begin
      unique case (wb_adr_in)
        SAS_CTRL_OFS: next_ctrl = merge(ctrl, wb_dat_in, wb_sel_in, SAS_CTRL_WMASK);
        SAS_SEQ_OFS: next_seq = merge(seq, wb_dat_in, wb_sel_in, SAS_SEQ_WMASK);
        SAS_TIMING_OFS: next_timing = merge(timing, wb_dat_in, wb_sel_in, SAS_TIMING_WMASK);
        SAS_INSEL_OFS: next_insel = merge(insel, wb_dat_in, wb_sel_in, 32'hffff_ffff);
        SAS_PINCFG_OFS: next_pincfg = merge(pincfg, wb_dat_in, wb_sel_in, SAS_HALF_WMASK);
        SAS_SCAN_OFS: next_scan = merge(scan, wb_dat_in, wb_sel_in, SAS_HALF_WMASK);
        SAS_MASK_OFS: next_mask = 2'(merge({30'h0, mask}, wb_dat_in, wb_sel_in, SAS_IRQ_WMASK));
        default: ;
      endcase
    end
    // Reads; a status read clears the sticky bits it returns.
    if (bus_rd) begin
      if (is_buf) begin
        next_rdat = {16'h0000, fmt(rbuf[wb_adr_in[5:2]], ctrl[SAS_FORM_LSB +: 2])};
      end else begin
        unique case (wb_adr_in)
          SAS_CTRL_OFS: next_rdat = ctrl;
          SAS_SEQ_OFS: next_rdat = seq | (32'(half) << SAS_HALF_BIT);
          SAS_TIMING_OFS: next_rdat = timing;
          SAS_INSEL_OFS: next_rdat = insel;
          SAS_PINCFG_OFS: next_rdat = pincfg;
          SAS_SCAN_OFS: next_rdat = scan;
          SAS_STAT_OFS: begin
            next_rdat = {30'h0, stat};
            next_stat = 2'h0;
          end
          SAS_MASK_OFS: next_rdat = {30'h0, mask};
          default: next_rdat = 32'h0000_0000;
        endcase
      end
    end
    // Sequencer; switching off wins over every start and trigger.
    if (!on) begin
      if (state != SAS_IDLE) begin
        next_stat[SAS_ST_ABORT] = 1'b1;
      end
      next_state = SAS_IDLE;
      next_step = 4'h0;
      next_chan = 2'h0;
    end else begin
      unique case (state)
        SAS_IDLE: begin
          if (ctrl[SAS_SREQ_BIT]) begin
            next_state = SAS_SAMPLE;
            next_acq_cnt = 5'h00;
            next_ctrl[SAS_DONE_BIT] = 1'b0;
          end
        end
        SAS_SAMPLE: begin
          if (tad_tick) begin
            next_acq_cnt = acq_cnt + 5'h01;
          end
          if (trig_hit) begin
            next_state = SAS_CONVERT;
            next_step = 4'h0;
            next_chan = 2'h0;
            next_tad_cnt = 6'h00;
            if (trig != SAS_TRIG_SW) begin
              next_ctrl[SAS_SREQ_BIT] = 1'b0;
            end
          end
        end
        SAS_CONVERT: begin
          if (tad_tick) begin
            next_step = step + 4'h1;
            if (step == 4'h0) begin
              next_sar = SAS_SAR_MSB;
            end else if (step <= 4'(SAS_RES_W)) begin
              // Keep the trial bit when the input is at or above the trial level.
              next_sar[4'(SAS_RES_W) - step] = comparator_in;
              if (step != 4'(SAS_RES_W)) begin
                next_sar[4'(SAS_RES_W) - step - 4'h1] = 1'b1;
              end
            end else begin
              buf_we = 1'b1;
              next_step = 4'h0;
              next_wr_ptr = wr_ptr + 4'h1;
              next_sample_request_cnt = sample_request_cnt + 4'h1;
              if (group_done) begin
                next_ctrl[SAS_DONE_BIT] = 1'b1;
                next_stat[SAS_ST_DONE] = 1'b1;
                next_sample_request_cnt = 4'h0;
                next_use_b = 1'b0;
                next_half = seq[SAS_SPLIT_BIT] & ~half;
                next_wr_ptr = seq[SAS_SPLIT_BIT] ? {~half, 3'h0} : 4'h0;
              end
              if (last_chan) begin
                next_chan = 2'h0;
                next_acq_cnt = 5'h00;
                if (seq[SAS_ALTERNATE_INPUT_SEL_BIT] && !group_done) begin
                  next_use_b = ~use_b;
                end
                if (ctrl[SAS_AUTO_SAMPLE_EN_BIT]) begin
                  next_state = SAS_SAMPLE;
                  next_ctrl[SAS_SREQ_BIT] = 1'b1;
                end else begin
                  next_state = SAS_IDLE;
                end
              end else begin
                next_chan = chan + 2'h1;
              end
            end
          end
        end
        default: next_state = SAS_IDLE;
      endcase
    end
    // Track lines: in sequential mode channels not yet converted keep tracking.
    next_track = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || chps == 2'h2 || chps == 2'h3 || (i == 1 && chps == 2'h1)) begin
        next_track[i] = (next_state == SAS_SAMPLE) ||
          (next_state == SAS_CONVERT && !ctrl[SAS_SIMULTANEOUS_SAMPLE_SEL_BIT] && 2'(i) > next_chan);
      end
    end
    next_chsel = next_use_b ? next_insel[31:16] : next_insel[15:0];
    next_irq = |(next_stat & next_mask);
  end

  // State and register flops.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= SAS_IDLE;
      tad_cnt <= 6'h00;
      acq_cnt <= 5'h00;
      step <= 4'h0;
      chan <= 2'h0;
      sar <= 10'h000;
      sample_request_cnt <= 4'h0;
      wr_ptr <= 4'h0;
      half <= 1'b0;
      use_b <= 1'b0;
      ctrl <= 32'h0000_0000;
      seq <= 32'h0000_0000;
      timing <= 32'h0000_0000;
      insel <= 32'h0000_0000;
      pincfg <= 32'h0000_0000;
      scan <= 32'h0000_0000;
      stat <= 2'h0;
      mask <= 2'h0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
      irq <= 1'b0;
      track <= 4'h0;
      chsel <= 16'h0000;
    end else begin
      state <= next_state;
      tad_cnt <= next_tad_cnt;
      acq_cnt <= next_acq_cnt;
      step <= next_step;
      chan <= next_chan;
      sar <= next_sar;
      sample_request_cnt <= next_sample_request_cnt;
      wr_ptr <= next_wr_ptr;
      half <= next_half;
      use_b <= next_use_b;
      ctrl <= next_ctrl;
      seq <= next_seq;
      timing <= next_timing;
      insel <= next_insel;
      pincfg <= next_pincfg;
      scan <= next_scan;
      stat <= next_stat;
      mask <= next_mask;
      ack <= next_ack;
      rdat <= next_rdat;
      irq <= next_irq;
      track <= next_track;
      chsel <= next_chsel;
    end
  end

  // Result memory: only the converter writes it, software reads it.
  always_ff @(posedge clk_in) begin
    if (buf_we) begin
      rbuf[wr_ptr] <= sar;
    end
  end

  // Outputs straight from flops.
  assign wb_ack_out = ack;
  assign wb_dat_out = rdat;
  assign dac_code_out = sar;
  assign conv_chan_out = chan;
  assign sh_track_out = track;
  assign input_sel_out = chsel;
  assign ref_pins_sel_out = ctrl[SAS_REF_BIT];
  assign pin_analog_out = pincfg[15:0];
  assign irq_out = irq;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_sampling;
    state == SAS_SAMPLE && on;
  endsequence

  off_forces_idle_a: assert property (!on |=> state == SAS_IDLE)
    else $error("sequencer not idle after switch off");
  off_no_store_a: assert property (!on |-> !buf_we)
    else $error("buffer written while off");
  start_sample_a: assert property (state == SAS_IDLE && on && ctrl[SAS_SREQ_BIT]
                                   |=> state == SAS_SAMPLE)
    else $error("sample request did not start acquisition");
  sw_trigger_a: assert property (s_sampling ##0 (trig == SAS_TRIG_SW &&
                                 !ctrl[SAS_SREQ_BIT]) |=> state == SAS_CONVERT)
    else $error("cleared request did not start conversion");
  ext_trigger_a: assert property (s_sampling ##0 (trig == SAS_TRIG_EXT && ext_trig_in)
                                  |=> state == SAS_CONVERT)
    else $error("external trigger missed");
  store_step_a: assert property (buf_we |-> state == SAS_CONVERT &&
                                 step == SAS_LAST_STEP && tad_tick)
    else $error("result stored at wrong step");
  buf_readonly_a: assert property (bus_wr && is_buf && !buf_we
                                   |=> rbuf[$past(wb_adr_in[5:2])] ==
                                   $past(rbuf[wb_adr_in[5:2]]))
    else $error("software write changed buffer");
  done_count_a: assert property ($rose(ctrl[SAS_DONE_BIT]) |-> $past(group_done))
    else $error("done set before sample count reached");
  split_half_a: assert property (seq[SAS_SPLIT_BIT] && buf_we && group_done
                                 |=> wr_ptr[3] == half)
    else $error("split buffer half did not switch");
  int_read_a: assert property (bus_rd && is_buf && ctrl[SAS_FORM_LSB +: 2] == 2'h0
                               |=> wb_ack_out && wb_dat_out[31:10] == 22'h0)
    else $error("integer result has upper bits set");
endmodule

// ### tb/sas_adc_model.sv
// Behavioural analog side: fixed input levels, four sample-holds and the comparator.
`timescale 1ns/10ps
module sas_adc_model #(
  parameter int LVL_BASE = 64,
  parameter int LVL_STEP = 59
) (
  input wire logic clk_in,
  input wire logic [9:0] dac_code_in,
  input wire logic [1:0] conv_chan_in,
  input wire logic [3:0] sh_track_in,
  input wire logic [15:0] input_sel_in,
  output logic comparator_out
);
  logic [9:0] held [4];
  // A tracking sample-hold follows the level of the input routed onto it.
  always_ff @(posedge clk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (sh_track_in[k]) begin
        held[k] <= 10'(LVL_BASE + LVL_STEP * int'(input_sel_in[4*k +: 4]));
      end
    end
  end
  // The comparator is high while the held level is at or above the trial code.
  assign comparator_out = (held[conv_chan_in] >= dac_code_in);
endmodule

// ### tb/test_sas_sequencer.sv
// Self-checking bench for the converter sequencer over its Wishbone registers.
`timescale 1ns/10ps
module test_sas_sequencer import sas_pkg::*;;
  localparam int LVL_BASE = 64;
  localparam int LVL_STEP = 59;
  logic clk_in;
  logic reset_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic timer_trig_in = 1'b0;
  logic ext_trig_in = 1'b0;
  logic comparator_in;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, ref_pins_sel_out, irq_out;
  logic [9:0] dac_code_out;
  logic [1:0] conv_chan_out;
  logic [3:0] sh_track_out;
  logic [15:0] input_sel_out, pin_analog_out;
  int n_fail = 0;
  int samples_checked = 0;

  sas_sequencer u_sas_sequencer (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .timer_trig_in(timer_trig_in), .ext_trig_in(ext_trig_in),
    .comparator_in(comparator_in), .dac_code_out(dac_code_out), .conv_chan_out(conv_chan_out),
    .sh_track_out(sh_track_out), .input_sel_out(input_sel_out),
    .ref_pins_sel_out(ref_pins_sel_out), .pin_analog_out(pin_analog_out), .irq_out(irq_out));

  sas_adc_model #(.LVL_BASE(LVL_BASE), .LVL_STEP(LVL_STEP)) u_sas_adc_model (.clk_in(clk_in),
    .dac_code_in(dac_code_out), .conv_chan_in(conv_chan_out), .sh_track_in(sh_track_out),
    .input_sel_in(input_sel_out), .comparator_out(comparator_in));

  // The 250 MHz system clock.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Expected code of an analog input, from the levels given to the model.
  function automatic logic [31:0] lvl(input int i);
    return 32'(LVL_BASE + LVL_STEP * i);
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high at a rising edge.
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel, output logic [31:0] rd);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wb_sel_in <= sel;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 50) begin
      check(32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_io(1'b1, adr, dat, 4'hf, d);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_io(1'b0, adr, 32'h0, 4'hf, d);
    check(d, exp);
  endtask

  // Waits a bounded time for the interrupt line and returns the cycles spent.
  task automatic wait_irq(output int n);
    n = 0;
    while (irq_out !== 1'b1) begin
      @(posedge clk_in);
      n++;
      if (n > 4000) begin
        check(32'h0, 32'h1);
        finish_test();
      end
    end
  endtask

  // Pulses a trigger input for two cycles.
  task automatic pulse(input bit timer);
    if (timer) timer_trig_in <= 1'b1;
    else ext_trig_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    timer_trig_in <= 1'b0;
    ext_trig_in <= 1'b0;
  endtask

  // One single-channel conversion with the given trigger source and input.
  task automatic run_one(input logic [2:0] code, input logic [3:0] src);
    int n;
    wr(SAS_CTRL_OFS, 32'h0);
    wr(SAS_SEQ_OFS, 32'h0);
    wr(SAS_INSEL_OFS, {28'h0, src});
    wr(SAS_TIMING_OFS, 32'h0203);
    wr(SAS_CTRL_OFS, {24'h0, code, 5'h03});
    repeat (2) @(posedge clk_in);
    check({31'h0, sh_track_out[0]}, 32'h1);
    repeat (4) @(posedge clk_in);
    case (code)
      SAS_TRIG_SW: wr(SAS_CTRL_OFS, 32'h1);
      SAS_TRIG_TIMER: pulse(1'b1);
      SAS_TRIG_EXT: pulse(1'b0);
      default: ;
    endcase
    wait_irq(n);
    if (code == SAS_TRIG_SW) check(32'(n >= 40 && n <= 56), 32'h1);
    rd_chk(SAS_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    rd_chk(SAS_BUF_OFS, lvl(src));
    rd_chk(SAS_CTRL_OFS, {24'h0, code, 5'h05});
  endtask

  // Main sequence.
  initial begin
    int n;
    logic [31:0] d;
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_chk(SAS_CTRL_OFS, 32'h0);
    rd_chk(SAS_STAT_OFS, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'h0);
    wr(SAS_TIMING_OFS, 32'hffff_ffff);
    rd_chk(SAS_TIMING_OFS, 32'h1f3f);
    wb_io(1'b1, SAS_TIMING_OFS, 32'h0, 4'h1, d);
    rd_chk(SAS_TIMING_OFS, 32'h1f00);
    wr(SAS_PINCFG_OFS, 32'h0000_a5c3);
    rd_chk(SAS_PINCFG_OFS, 32'ha5c3);
    wr(SAS_SCAN_OFS, 32'h0001_ffff);
    rd_chk(SAS_SCAN_OFS, 32'hffff);
    wr(SAS_INSEL_OFS, 32'h1234_5678);
    wr(SAS_CTRL_OFS, 32'h0000_0404);
    repeat (2) @(posedge clk_in);
    check({16'h0, pin_analog_out}, 32'ha5c3);
    check({16'h0, input_sel_out}, 32'h5678);
    check({31'h0, ref_pins_sel_out}, 32'h1);
    rd_chk(SAS_CTRL_OFS, 32'h400);
    wr(SAS_MASK_OFS, 32'h3);
    // Every trigger source, each on a different input.
    for (int i = 0; i < 4; i++) begin
      run_one(i == 3 ? SAS_TRIG_AUTO : 3'(i), 4'(i * 5));
    end
    // Four sample-holds, four results per interrupt.
    wr(SAS_CTRL_OFS, 32'h0);
    wr(SAS_SEQ_OFS, 32'h83);
    wr(SAS_INSEL_OFS, 32'h0000_c963);
    wr(SAS_CTRL_OFS, 32'h13);
    repeat (3) @(posedge clk_in);
    check({28'h0, sh_track_out}, 32'hf);
    wr(SAS_CTRL_OFS, 32'h11);
    wait_irq(n);
    check(32'(n >= 170), 32'h1);
    rd_chk(SAS_STAT_OFS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      rd_chk(SAS_BUF_OFS + 8'(4 * k), lvl(3 * (k + 1)));
    end
    // Split buffer with automatic restart: halves alternate per interrupt.
    wr(SAS_CTRL_OFS, 32'h0);
    wr(SAS_SEQ_OFS, 32'h10);
    wr(SAS_INSEL_OFS, 32'h7);
    wr(SAS_TIMING_OFS, 32'h0103);
    wr(SAS_CTRL_OFS, 32'heb);
    wait_irq(n);
    rd_chk(SAS_STAT_OFS, 32'h1);
    wait_irq(n);
    wr(SAS_CTRL_OFS, 32'h0);
    wb_io(1'b0, SAS_STAT_OFS, 32'h0, 4'hf, d);
    rd_chk(SAS_BUF_OFS, lvl(7));
    rd_chk(SAS_BUF_OFS + 8'h20, lvl(7));
    rd_chk(SAS_BUF_OFS + 8'h04, lvl(6));
    // Two channels sampled in turn, inputs alternating between the two groups.
    wr(SAS_SEQ_OFS, 32'h63);
    wr(SAS_INSEL_OFS, 32'h00a4_0051);
    wr(SAS_CTRL_OFS, 32'heb);
    wait_irq(n);
    wr(SAS_CTRL_OFS, 32'h0);
    wb_io(1'b0, SAS_STAT_OFS, 32'h0, 4'hf, d);
    rd_chk(SAS_BUF_OFS, lvl(1));
    rd_chk(SAS_BUF_OFS + 8'h04, lvl(5));
    rd_chk(SAS_BUF_OFS + 8'h08, lvl(4));
    rd_chk(SAS_BUF_OFS + 8'h0c, lvl(10));
    // Switching off mid-conversion, abort bit masked from the interrupt.
    wr(SAS_MASK_OFS, 32'h1);
    wr(SAS_SEQ_OFS, 32'h0);
    wr(SAS_INSEL_OFS, 32'he);
    wr(SAS_TIMING_OFS, 32'h0109);
    wr(SAS_CTRL_OFS, 32'h3);
    repeat (4) @(posedge clk_in);
    wr(SAS_CTRL_OFS, 32'h1);
    repeat (30) @(posedge clk_in);
    wr(SAS_CTRL_OFS, 32'h0);
    repeat (200) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    rd_chk(SAS_STAT_OFS, 32'h2);
    rd_chk(SAS_BUF_OFS, lvl(1));
    // Requests and triggers while off; buffer writes.
    wr(SAS_CTRL_OFS, 32'h42);
    pulse(1'b0);
    check({28'h0, sh_track_out}, 32'h0);
    repeat (100) @(posedge clk_in);
    rd_chk(SAS_STAT_OFS, 32'h0);
    wr(SAS_BUF_OFS, 32'h155);
    rd_chk(SAS_BUF_OFS, lvl(1));
    // The remaining result formats on the same stored code.
    wr(SAS_CTRL_OFS, 32'h100);
    rd_chk(SAS_BUF_OFS, {16'h0, 16'(lvl(1) - 32'h200)});
    wr(SAS_CTRL_OFS, 32'h200);
    rd_chk(SAS_BUF_OFS, lvl(1) << 6);
    wr(SAS_CTRL_OFS, 32'h300);
    rd_chk(SAS_BUF_OFS, {16'h0, 16'((lvl(1) - 32'h200) << 6)});
    finish_test();
  end
endmodule
